/* hw/tlic_pkg.sv */
// Constants shared by the two-level interrupt controller files.
// Assumes an 8-bit register port and a core that fetches 16-bit vectors.
package tlic_pkg;

    // Register offsets on the 8-bit register port
    localparam logic [7:0] TLIC_OFS_ENABLE = 8'ha8;
    localparam logic [7:0] TLIC_OFS_SECOND = 8'ha9;
    localparam logic [7:0] TLIC_OFS_LEVEL = 8'hb8;
    localparam logic [7:0] TLIC_OFS_EVT_STAT = 8'hc0;
    localparam logic [7:0] TLIC_OFS_EVT_MASK = 8'hc1;
    localparam logic [7:0] TLIC_OFS_SVC_STAT = 8'hc2;

    // Reset values
    localparam logic [7:0] TLIC_RST_ENABLE = 8'h00;
    localparam logic [7:0] TLIC_RST_SECOND = 8'ha0;
    localparam logic [7:0] TLIC_RST_LEVEL = 8'h00;
    localparam logic [7:0] TLIC_RST_EVT_MASK = 8'h00;

    // Enable and level register fields, same order in both
    localparam int TLIC_BIT_GLOBAL = 7;
    localparam int TLIC_BIT_CONV = 6;
    localparam int TLIC_BIT_TMR2 = 5;
    localparam int TLIC_BIT_UART = 4;
    localparam int TLIC_BIT_TMR1 = 3;
    localparam int TLIC_BIT_EXT1 = 2;
    localparam int TLIC_BIT_TMR0 = 1;
    localparam int TLIC_BIT_EXT0 = 0;
    localparam logic [7:0] TLIC_LEVEL_MASK = 8'h7f;

    // Secondary register fields
    localparam int TLIC_BIT_INTERVAL_LVL = 6;
    localparam int TLIC_BIT_SUPPLY_LVL = 5;
    localparam int TLIC_BIT_SYNC_LVL = 4;
    localparam int TLIC_BIT_MUST_ZERO = 3;
    localparam int TLIC_BIT_INTERVAL_EN = 2;
    localparam int TLIC_BIT_SUPPLY_EN = 1;
    localparam int TLIC_BIT_SYNC_EN = 0;

    // Event status fields
    localparam int TLIC_EVT_LOW_TAKEN = 0;
    localparam int TLIC_EVT_HIGH_TAKEN = 1;
    localparam int TLIC_EVT_PREEMPT = 2;
    localparam int TLIC_EVT_BAD_WRITE = 3;
    localparam int TLIC_EVT_WIDTH = 4;

    // Sources in polling order, index 0 polled first
    localparam int TLIC_NUM_SRC = 11;
    localparam int TLIC_SRC_SUPPLY = 0;
    localparam int TLIC_SRC_WATCHDOG = 1;
    localparam int TLIC_SRC_EXT0 = 2;
    localparam int TLIC_SRC_CONV = 3;
    localparam int TLIC_SRC_TMR0 = 4;
    localparam int TLIC_SRC_EXT1 = 5;
    localparam int TLIC_SRC_TMR1 = 6;
    localparam int TLIC_SRC_SYNC = 7;
    localparam int TLIC_SRC_UART = 8;
    localparam int TLIC_SRC_TMR2 = 9;
    localparam int TLIC_SRC_INTERVAL = 10;

    // Vector per source, indexed as above
    localparam logic [15:0] TLIC_VEC_TABLE [0:TLIC_NUM_SRC-1] = '{
        16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
        16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};

    // Dispatch sequencer, Gray coded along idle, push, load
    typedef enum logic [1:0] {
        TLIC_ST_IDLE = 2'b00,
        TLIC_ST_PUSH = 2'b01,
        TLIC_ST_LOAD = 2'b11
    } tlic_state_type;

endpackage : tlic_pkg

/* hw/tlic_pick_if.sv */
// Carries eligible requests to the polling picker and its verdict back.
// Assumes both ends run on the same clock; the picker is purely combinational.
interface tlic_pick_if;
    import tlic_pkg::*;
    logic [TLIC_NUM_SRC-1:0] high_req;
    logic [TLIC_NUM_SRC-1:0] low_req;
    logic found;
    logic high;
    logic [3:0] index;

    modport picker (input high_req, input low_req, output found, output high, output index);
    modport owner (output high_req, output low_req, input found, input high, input index);
endinterface : tlic_pick_if

/* hw/tlic_pick.sv */
// Fixed-order picker: high level first, then lowest polling index.
// Assumes requests arrive already gated by enables and service state.
module tlic_pick
    import tlic_pkg::*;
(
    // Requests in, verdict out
    tlic_pick_if.picker pick
);

    function automatic logic [3:0] tlic_first_set(input logic [TLIC_NUM_SRC-1:0] vec);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = TLIC_NUM_SRC - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    always_comb begin
        pick.found = |pick.high_req || |pick.low_req;
        pick.high = |pick.high_req;
        if (|pick.high_req) begin // [RULE8]
            pick.index = tlic_first_set(pick.high_req); // [RULE10] [RULE15]
        end else begin
            pick.index = tlic_first_set(pick.low_req); // [RULE10]
        end
    end

endmodule // tlic_pick

/* hw/tlic_top.sv */
// Two-level interrupt controller: enables, levels, polling and vector dispatch.
// Assumes source flags come from logic on clk_in and a core that acks at an
// instruction boundary and signals its interrupt return with a one-cycle pulse.
// Unmapped offsets read zero.
//
// What this block does
// RULE1: Enable bit 7 gates every source; with it clear nothing is requested.
// RULE2: Enable bits 6..0 switch converter, timer 2, UART, timer 1, ext 1, timer 0, ext 0.
// RULE3: Level bits 6..0 follow the enable order, 1 is high, bit 7 is reserved.
// RULE4: Secondary bits 6, 5, 4 pick the level of interval counter, supply monitor, sync port.
// RULE5: Secondary bits 2, 1, 0 enable interval counter, supply monitor, sync port.
// RULE6: Software keeps secondary bit 3 at zero when it writes that register.
// RULE7: An enabled high-level request may preempt a low-level service routine.
// RULE8: When levels meet in one cycle the high-level request goes first.
// RULE9: A routine is never preempted by a request of its own level.
// RULE10: Same-level requests are polled in one fixed order from supply monitor to interval.
// RULE11: Paired flags of UART, timer 2 and sync port each form one request and one vector.
// RULE12: On acceptance the program counter is pushed, then loaded with the vector.
// RULE13: Classic vectors sit at 0003, 000b, 0013, 001b, 0023 and 002b hex.
// RULE14: Extended vectors sit at 0033, 003b, 0043, 0053 and 005b hex.
// RULE15: Watchdog wins the tie with external 0 at the shared polling rank.
// RULE16: Service level is tracked per level and freed by the interrupt return.
//
// Added by the designer: the plain strobed port.
module tlic_top
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,

    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,

    // Source flags
    input wire logic supply_mon_irq_in,
    input wire logic watchdog_irq_in,
    input wire logic ext0_irq_in,
    input wire logic conv_done_irq_in,
    input wire logic tmr0_overflow_in,
    input wire logic ext1_irq_in,
    input wire logic tmr1_overflow_in,

    // Paired flags, then the unpaired interval flag
    input wire logic two_wire_irq_in,
    input wire logic four_wire_irq_in,
    input wire logic uart_rx_done_in,
    input wire logic uart_tx_done_in,
    input wire logic tmr2_overflow_in,
    input wire logic tmr2_ext_flag_in,
    input wire logic interval_irq_in,

    // Core handshake
    output logic core_irq_req_out,
    input wire logic core_ack_in,
    input wire logic core_reti_in,
    output logic push_pc_out,
    output logic load_pc_out,
    output logic [15:0] vector_out,
    output logic [3:0] source_out,

    // Event interrupt
    output logic event_irq_out
);

    // Picker link
    tlic_pick_if pick ();

    // Registers
    logic [7:0] enable_reg;
    logic [7:0] second_reg;
    logic [6:0] level_reg;

    logic [TLIC_EVT_WIDTH-1:0] evt_stat_reg;
    logic [TLIC_EVT_WIDTH-1:0] evt_mask_reg;
    logic [7:0] rdata_reg;

    // Core side state
    logic active_hi_reg;
    logic active_lo_reg;
    tlic_state_type state_reg;

    logic [3:0] taken_idx_reg;
    logic taken_high_reg;

    // Core outputs
    logic push_pc_reg;
    logic load_pc_reg;
    logic [15:0] vector_reg;
    logic [3:0] source_reg;

    // Requests
    logic [TLIC_NUM_SRC-1:0] raw_req;
    logic [TLIC_NUM_SRC-1:0] src_en;
    logic [TLIC_NUM_SRC-1:0] src_high;
    logic [TLIC_NUM_SRC-1:0] gated_req;

    logic high_ok;
    logic low_ok;
    logic accept;

    // Events
    logic [TLIC_EVT_WIDTH-1:0] evt_set;
    logic evt_rd_clear;

    // Paired flags merge before polling
    always_comb begin
        raw_req = '0;

        raw_req[TLIC_SRC_SUPPLY] = supply_mon_irq_in;
        raw_req[TLIC_SRC_WATCHDOG] = watchdog_irq_in;
        raw_req[TLIC_SRC_EXT0] = ext0_irq_in;
        raw_req[TLIC_SRC_CONV] = conv_done_irq_in;
        raw_req[TLIC_SRC_TMR0] = tmr0_overflow_in;
        raw_req[TLIC_SRC_EXT1] = ext1_irq_in;
        raw_req[TLIC_SRC_TMR1] = tmr1_overflow_in;

        raw_req[TLIC_SRC_SYNC] = two_wire_irq_in | four_wire_irq_in; // [RULE11]
        raw_req[TLIC_SRC_UART] = uart_rx_done_in | uart_tx_done_in; // [RULE11]
        raw_req[TLIC_SRC_TMR2] = tmr2_overflow_in | tmr2_ext_flag_in; // [RULE11]

        raw_req[TLIC_SRC_INTERVAL] = interval_irq_in;
    end

    // Per-source enables mapped into polling order
    always_comb begin
        src_en = '0;

        src_en[TLIC_SRC_SUPPLY] = second_reg[TLIC_BIT_SUPPLY_EN]; // [RULE5]
        // No enable bit exists for the watchdog; only the global gate stops it
        src_en[TLIC_SRC_WATCHDOG] = 1'b1;

        src_en[TLIC_SRC_EXT0] = enable_reg[TLIC_BIT_EXT0]; // [RULE2]
        src_en[TLIC_SRC_CONV] = enable_reg[TLIC_BIT_CONV]; // [RULE2]
        src_en[TLIC_SRC_TMR0] = enable_reg[TLIC_BIT_TMR0]; // [RULE2]
        src_en[TLIC_SRC_EXT1] = enable_reg[TLIC_BIT_EXT1]; // [RULE2]
        src_en[TLIC_SRC_TMR1] = enable_reg[TLIC_BIT_TMR1]; // [RULE2]

        src_en[TLIC_SRC_SYNC] = second_reg[TLIC_BIT_SYNC_EN]; // [RULE5]
        src_en[TLIC_SRC_UART] = enable_reg[TLIC_BIT_UART]; // [RULE2]
        src_en[TLIC_SRC_TMR2] = enable_reg[TLIC_BIT_TMR2]; // [RULE2]

        src_en[TLIC_SRC_INTERVAL] = second_reg[TLIC_BIT_INTERVAL_EN]; // [RULE5]
    end

    // Per-source level, 1 is high
    always_comb begin
        src_high = '0;

        src_high[TLIC_SRC_SUPPLY] = second_reg[TLIC_BIT_SUPPLY_LVL]; // [RULE4]
        // Watchdog has no level bit; high so it can preempt any low-level routine
        src_high[TLIC_SRC_WATCHDOG] = 1'b1;

        src_high[TLIC_SRC_EXT0] = level_reg[TLIC_BIT_EXT0]; // [RULE3]
        src_high[TLIC_SRC_CONV] = level_reg[TLIC_BIT_CONV]; // [RULE3]
        src_high[TLIC_SRC_TMR0] = level_reg[TLIC_BIT_TMR0]; // [RULE3]
        src_high[TLIC_SRC_EXT1] = level_reg[TLIC_BIT_EXT1]; // [RULE3]
        src_high[TLIC_SRC_TMR1] = level_reg[TLIC_BIT_TMR1]; // [RULE3]

        src_high[TLIC_SRC_SYNC] = second_reg[TLIC_BIT_SYNC_LVL]; // [RULE4]
        src_high[TLIC_SRC_UART] = level_reg[TLIC_BIT_UART]; // [RULE3]
        src_high[TLIC_SRC_TMR2] = level_reg[TLIC_BIT_TMR2]; // [RULE3]

        src_high[TLIC_SRC_INTERVAL] = second_reg[TLIC_BIT_INTERVAL_LVL]; // [RULE4]
    end

    assign gated_req = raw_req & src_en & {TLIC_NUM_SRC{enable_reg[TLIC_BIT_GLOBAL]}}; // [RULE1]

    // High may run over a low routine, never over another high one
    assign high_ok = !active_hi_reg; // [RULE7] [RULE9]
    assign low_ok = !active_hi_reg && !active_lo_reg; // [RULE9]

    assign pick.high_req = gated_req & src_high & {TLIC_NUM_SRC{high_ok}};
    assign pick.low_req = gated_req & ~src_high & {TLIC_NUM_SRC{low_ok}};

    // Polling order
    tlic_pick u_pick (
        .pick(pick.picker)
    );

    // Request held low while a dispatch is in flight
    assign core_irq_req_out = pick.found && (state_reg == TLIC_ST_IDLE);
    assign accept = core_irq_req_out && core_ack_in;

    // Dispatch sequencer
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_reg <= TLIC_ST_IDLE;
        end else begin
            case (state_reg)
                TLIC_ST_IDLE: begin
                    if (accept) begin
                        state_reg <= TLIC_ST_PUSH;
                    end
                end

                TLIC_ST_PUSH: begin
                    state_reg <= TLIC_ST_LOAD; // [RULE12]
                end

                TLIC_ST_LOAD: begin
                    state_reg <= TLIC_ST_IDLE;
                end

                default: begin
                    state_reg <= TLIC_ST_IDLE;
                end
            endcase
        end
    end

    // Winner frozen at acceptance so late requests cannot swap it
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            taken_idx_reg <= 4'h0;
            taken_high_reg <= 1'b0;
        end else if (accept) begin
            taken_idx_reg <= pick.index;
            taken_high_reg <= pick.high;
        end
    end

    // Push strobe first, load strobe with vector on the next cycle
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            push_pc_reg <= 1'b0;
            load_pc_reg <= 1'b0;
            vector_reg <= 16'h0000;
            source_reg <= 4'h0;
        end else begin

            push_pc_reg <= accept; // [RULE12]
            load_pc_reg <= (state_reg == TLIC_ST_PUSH); // [RULE12]

            if (state_reg == TLIC_ST_PUSH) begin
                vector_reg <= TLIC_VEC_TABLE[taken_idx_reg]; // [RULE13] [RULE14]
                source_reg <= taken_idx_reg;
            end
        end
    end

    assign push_pc_out = push_pc_reg;
    assign load_pc_out = load_pc_reg;

    assign vector_out = vector_reg;
    assign source_out = source_reg;

    // Service level tracking; return frees the higher level first
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            active_hi_reg <= 1'b0;
            active_lo_reg <= 1'b0;
        end else if (state_reg == TLIC_ST_LOAD) begin
            if (taken_high_reg) begin
                active_hi_reg <= 1'b1; // [RULE16]
            end else begin
                active_lo_reg <= 1'b1; // [RULE16]
            end
        end else if (core_reti_in) begin
            if (active_hi_reg) begin
                active_hi_reg <= 1'b0; // [RULE16]
            end else begin
                active_lo_reg <= 1'b0; // [RULE16]
            end
        end
    end

    // Software registers
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            enable_reg <= TLIC_RST_ENABLE;
            second_reg <= TLIC_RST_SECOND;
            level_reg <= TLIC_RST_LEVEL[6:0];
            evt_mask_reg <= TLIC_RST_EVT_MASK[TLIC_EVT_WIDTH-1:0];
        end else if (reg_wr_in) begin
            if (reg_addr_in == TLIC_OFS_ENABLE) begin
                enable_reg <= reg_wdata_in; // [RULE1] [RULE2]
            end else if (reg_addr_in == TLIC_OFS_SECOND) begin
                // Stored as written; a set must-be-zero bit is only flagged
                second_reg <= reg_wdata_in; // [RULE4] [RULE5]
            end else if (reg_addr_in == TLIC_OFS_LEVEL) begin
                level_reg <= reg_wdata_in[6:0]; // [RULE3]
            end else if (reg_addr_in == TLIC_OFS_EVT_MASK) begin
                evt_mask_reg <= reg_wdata_in[TLIC_EVT_WIDTH-1:0];
            end
        end
    end

    // Events of the controller itself
    always_comb begin
        evt_set = '0;

        evt_set[TLIC_EVT_LOW_TAKEN] = accept && !pick.high;
        evt_set[TLIC_EVT_HIGH_TAKEN] = accept && pick.high;
        evt_set[TLIC_EVT_PREEMPT] = accept && pick.high && active_lo_reg; // [RULE7]
        evt_set[TLIC_EVT_BAD_WRITE] = reg_wr_in && (reg_addr_in == TLIC_OFS_SECOND)
            && reg_wdata_in[TLIC_BIT_MUST_ZERO]; // [RULE6]
    end

    // Read-clear strobe
    assign evt_rd_clear = reg_rd_in && (reg_addr_in == TLIC_OFS_EVT_STAT);

    // Read clears, but an event in the same cycle survives
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            evt_stat_reg <= '0;
        end else if (evt_rd_clear) begin
            evt_stat_reg <= evt_set;
        end else begin
            evt_stat_reg <= evt_stat_reg | evt_set;
        end
    end

    assign event_irq_out = |(evt_stat_reg & evt_mask_reg);

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd_in) begin
            if (reg_addr_in == TLIC_OFS_ENABLE) begin
                rdata_reg <= enable_reg;
            end else if (reg_addr_in == TLIC_OFS_SECOND) begin
                rdata_reg <= second_reg;
            end else if (reg_addr_in == TLIC_OFS_LEVEL) begin
                rdata_reg <= {1'b0, level_reg} & TLIC_LEVEL_MASK;
            end else if (reg_addr_in == TLIC_OFS_EVT_STAT) begin
                rdata_reg <= {{(8 - TLIC_EVT_WIDTH){1'b0}}, evt_stat_reg};
            end else if (reg_addr_in == TLIC_OFS_EVT_MASK) begin
                rdata_reg <= {{(8 - TLIC_EVT_WIDTH){1'b0}}, evt_mask_reg};
            end else if (reg_addr_in == TLIC_OFS_SVC_STAT) begin
                rdata_reg <= {6'h00, active_hi_reg, active_lo_reg};
            end else begin
                rdata_reg <= 8'h00;
            end
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata_out = rdata_reg;

endmodule // tlic_top

/* bench/tlic_checker.sv */
// Port checker for the two-level interrupt controller.
// Assumes it is bound to tlic_top and sees only that module's ports.
module tlic_checker
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Core handshake
    input wire logic core_irq_req_out,
    input wire logic core_ack_in,
    input wire logic push_pc_out,
    input wire logic load_pc_out,
    input wire logic [15:0] vector_out,
    input wire logic [3:0] source_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // Shadow of the enable register, built from port writes alone
    logic [7:0] enable_reg;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            enable_reg <= TLIC_RST_ENABLE;
        end else if (reg_wr_in && reg_addr_in == TLIC_OFS_ENABLE) begin
            enable_reg <= reg_wdata_in;
        end
    end

    AST_PUSH_LOAD: assert property (core_irq_req_out && core_ack_in |=>
        push_pc_out && !load_pc_out ##1 load_pc_out && !push_pc_out)
        else $error("push and load did not follow an accepted request");
    AST_REQ_QUIET: assert property (push_pc_out || load_pc_out |-> !core_irq_req_out)
        else $error("request raised during push or load");
    AST_ACK_GAP: assert property (load_pc_out |=> !push_pc_out && !load_pc_out)
        else $error("dispatch strobes too close together");
    AST_VEC: assert property (load_pc_out |-> source_out < 4'd11 &&
        vector_out == TLIC_VEC_TABLE[source_out])
        else $error("vector does not match dispatched source");
    AST_VEC_HOLD: assert property ($changed(vector_out) |-> load_pc_out)
        else $error("vector changed outside a load");
    AST_GATE_OFF: assert property (!enable_reg[7] |-> !core_irq_req_out)
        else $error("request with global gate off");
    AST_EN_READ: assert property (reg_rd_in && reg_addr_in == TLIC_OFS_ENABLE |=>
        reg_rdata_out == $past(enable_reg))
        else $error("enable register read back wrong");
    AST_LVL_RSVD: assert property (reg_rd_in && reg_addr_in == TLIC_OFS_LEVEL |=>
        !reg_rdata_out[7])
        else $error("reserved level bit read as one");
endmodule // tlic_checker

bind tlic_top tlic_checker u_tlic_checker (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .core_irq_req_out(core_irq_req_out),
    .core_ack_in(core_ack_in), .push_pc_out(push_pc_out), .load_pc_out(load_pc_out),
    .vector_out(vector_out), .source_out(source_out));

/* bench/tlic_core_model.sv */
// Behavioural core: acks a request after a set delay, loads the vector, returns.
// Assumes the tlic_top handshake; delay and return are commanded by the bench.
module tlic_core_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Controller side
    input wire logic irq_req_in,
    input wire logic load_pc_in,
    input wire logic [15:0] vector_in,
    output logic ack_out,
    output logic reti_out,
    // Bench side
    input wire logic [3:0] delay_in,
    input wire logic reti_cmd_in,
    output logic got_out,
    output logic [15:0] pc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    // Ack once the request has been seen for delay_in cycles, like an instruction boundary
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ack_out <= 1'b0;
            wait_reg <= 4'h0;
        end else if (irq_req_in && !ack_out && wait_reg >= delay_in) begin
            ack_out <= 1'b1;
            wait_reg <= 4'h0;
        end else begin
            ack_out <= 1'b0;
            wait_reg <= irq_req_in ? wait_reg + 4'h1 : 4'h0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            got_out <= 1'b0;
            pc_out <= 16'h0000;
            reti_out <= 1'b0;
        end else begin
            got_out <= load_pc_in;
            reti_out <= reti_cmd_in;
            if (load_pc_in) begin
                pc_out <= vector_in;
            end
        end
    end
endmodule // tlic_core_model

/* bench/tlic_tb_top.sv */
// Self-checking bench for the two-level interrupt controller.
// Assumes the checker binds itself to tlic_top and a behavioural core model.
module tlic_tb_top;
    import tlic_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] EXP_VEC [0:10] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033,
        16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, reti_cmd = 1'b0;
    logic [13:0] src = 14'h0000, m;
    logic [3:0] dly = 4'h0;
    logic [31:0] seed = 32'h9ff43696;
    logic [7:0] rdata;
    logic req, ack, reti, load, evt, got;
    logic [15:0] vec, pc;
    logic [3:0] srcid;
    int errors = 0, num_checks = 0;

    tlic_top u_tlic_top (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .supply_mon_irq_in(src[0]), .watchdog_irq_in(src[1]), .ext0_irq_in(src[2]),
        .conv_done_irq_in(src[3]), .tmr0_overflow_in(src[4]), .ext1_irq_in(src[5]),
        .tmr1_overflow_in(src[6]), .two_wire_irq_in(src[7]), .four_wire_irq_in(src[11]),
        .uart_rx_done_in(src[8]), .uart_tx_done_in(src[12]), .tmr2_overflow_in(src[9]),
        .tmr2_ext_flag_in(src[13]), .interval_irq_in(src[10]), .core_irq_req_out(req),
        .core_ack_in(ack), .core_reti_in(reti), .push_pc_out(), .load_pc_out(load),
        .vector_out(vec), .source_out(srcid), .event_irq_out(evt));
    tlic_core_model u_tlic_core_model (.clk_in(clk_in), .rstn_in(rstn_in), .irq_req_in(req),
        .load_pc_in(load), .vector_in(vec), .ack_out(ack), .reti_out(reti), .delay_in(dly),
        .reti_cmd_in(reti_cmd), .got_out(got), .pc_out(pc));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Paired flags share one request, so either half is served alike
    function automatic logic [13:0] src_mask(input int idx, input logic alt);
        return (idx >= 7 && idx <= 9 && alt) ? 14'h1 << (idx + 4) : 14'h1 << idx;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        chk("read data", {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic set_src(input logic [13:0] add);
        @(posedge clk_in);
        src <= src | add;
    endtask
    task automatic serve(input int idx);
        int n;
        @(posedge clk_in);
        seed = xorshift(seed);
        dly <= {2'b00, seed[1:0]};
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (got !== 1'b1 && n < 100);
        if (n >= 100) begin
            errors++;
            finish_test();
        end
        chk("source", 16'(idx), {12'h000, srcid});
        chk("vector", EXP_VEC[idx], pc);
        @(posedge clk_in);
        src <= src & ~(src_mask(idx, 1'b0) | src_mask(idx, 1'b1));
    endtask
    task automatic ret();
        @(posedge clk_in);
        reti_cmd <= 1'b1;
        @(posedge clk_in);
        reti_cmd <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic quiet();
        repeat (6) begin
            @(negedge clk_in);
            chk("request", 16'h0000, {15'h0000, req});
        end
    endtask

    initial begin
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd_reg(TLIC_OFS_ENABLE, 8'h00);
        rd_reg(TLIC_OFS_SECOND, 8'ha0);
        rd_reg(TLIC_OFS_LEVEL, 8'h00);
        rd_reg(8'h10, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            wr_reg(TLIC_OFS_ENABLE, seed[15:8]);
            rd_reg(TLIC_OFS_ENABLE, seed[15:8]);
            wr_reg(TLIC_OFS_LEVEL, seed[7:0]);
            rd_reg(TLIC_OFS_LEVEL, seed[7:0] & 8'h7f);
        end
        wr_reg(TLIC_OFS_LEVEL, 8'h00);
        wr_reg(TLIC_OFS_EVT_MASK, 8'h0f);
        wr_reg(TLIC_OFS_SECOND, 8'h07);
        wr_reg(TLIC_OFS_ENABLE, 8'hff);
        // All sources at once; watchdog is the only high-level one here
        seed = xorshift(seed);
        m = 14'h0000;
        for (int i = 0; i < 11; i++) begin
            m = m | src_mask(i, seed[i]);
        end
        set_src(m);
        serve(1);
        ret();
        for (int i = 0; i < 11; i++) begin
            if (i != 1) begin
                serve(i);
                ret();
            end
        end
        chk("event line", 16'h0001, {15'h0000, evt});
        rd_reg(TLIC_OFS_EVT_STAT, 8'h03);
        wr_reg(TLIC_OFS_LEVEL, 8'h40);
        set_src(src_mask(0, 1'b0) | src_mask(3, 1'b0));
        serve(3);
        quiet();
        rd_reg(TLIC_OFS_SVC_STAT, 8'h02);
        ret();
        serve(0);
        set_src(src_mask(3, 1'b0));
        serve(3);
        rd_reg(TLIC_OFS_SVC_STAT, 8'h03);
        set_src(src_mask(2, 1'b0));
        ret();
        quiet();
        ret();
        serve(2);
        ret();
        rd_reg(TLIC_OFS_EVT_STAT, 8'h07);
        wr_reg(TLIC_OFS_SECOND, 8'h47);
        set_src(src_mask(0, 1'b0) | src_mask(10, 1'b0));
        serve(10);
        ret();
        serve(0);
        ret();
        wr_reg(TLIC_OFS_ENABLE, 8'h7f);
        set_src(src_mask(2, 1'b0));
        quiet();
        wr_reg(TLIC_OFS_ENABLE, 8'hfe);
        quiet();
        @(posedge clk_in);
        src <= 14'h0000;
        wr_reg(TLIC_OFS_SECOND, 8'h06);
        set_src(src_mask(7, 1'b1));
        quiet();
        wr_reg(TLIC_OFS_SECOND, 8'h07);
        serve(7);
        ret();
        // Bad secondary write: flagged, masked, then unmasked and cleared
        wr_reg(TLIC_OFS_EVT_STAT, 8'h00);
        rd_reg(TLIC_OFS_EVT_STAT, 8'h03);
        wr_reg(TLIC_OFS_EVT_MASK, 8'h00);
        wr_reg(TLIC_OFS_SECOND, 8'h0f);
        chk("event line", 16'h0000, {15'h0000, evt});
        wr_reg(TLIC_OFS_EVT_MASK, 8'h08);
        chk("event line", 16'h0001, {15'h0000, evt});
        rd_reg(TLIC_OFS_EVT_STAT, 8'h08);
        chk("event line", 16'h0000, {15'h0000, evt});
        finish_test();
    end
endmodule // tlic_tb_top
